// File: hdl/sine_ref_defines.svh
`ifndef SINE_REF_DEFINES_SVH
`define SINE_REF_DEFINES_SVH

// Clock rate
`define CLK_MHZ 25

// Integration target times
`define FAST_TIME_US 4000
`define MED_TIME_US 16700
`define SLOW_TIME_US 100000

// Register offsets
`define REG_CTRL 8'h00
`define REG_DIVIDE 8'h04
`define REG_FACTOR 8'h08
`define REG_STATUS 8'h0C
`define REG_RESULT 8'h10

// Control fields
`define CTRL_RATE_LSB 0
`define CTRL_QUICK_BIT 2
`define CTRL_START_BIT 8

// Status fields
`define STAT_BUSY_BIT 0
`define STAT_READY_BIT 1
`define STAT_DONE_BIT 2
`define STAT_IDX_LSB 4
`define STAT_PHASE_LSB 8

// Reset values and limits
`define DIVIDE_RESET 16'h0186
`define FACTOR_RESET 5'h04
`define FACTOR_MIN 5'h01
`define FACTOR_MAX 5'h18

// Conversions per acquisition
`define CONV_NORMAL 3'h6
`define CONV_QUICK 3'h5
`define CONV_SLOW 4'h8

// Divider thresholds for sync spacing and filter choice
`define LOW_FREQ_DIV 16'h0100
`define FILT_DIV_1 16'h0008
`define FILT_DIV_2 16'h0040
`define FILT_DIV_3 16'h0200

`endif

// File: hdl/sine_ref_pkg.sv
package sine_ref_pkg;

  typedef enum logic [1:0] {
    RATE_FAST = 2'b00,
    RATE_MEDIUM = 2'b01,
    RATE_SLOW = 2'b10
  } rate_type;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_SYNC = 2'b01,
    S_INTEG = 2'b10,
    S_DEINT = 2'b11
  } state_type;

  typedef struct packed {
    logic quick;
    rate_type rate;
  } ctrl_type;

endpackage

// File: hdl/sine_ref_dual_slope_sequencer.sv
// Operation
// - All timing comes from the one clock by counting and logic.
// - A 64f tick drives a six-bit divider chain down to the test frequency.
// - The divider bits address a 64-step sine table.
// - Each test table entry goes out as an eight-bit DAC word.
// - The smoothing filter setting follows the selected test frequency.
// - A reference table uses the same address, adding the phase to the top two bits for 90/180/270.
// - The reference word is the multiplying detector's digital control.
// - Integrate a controlled time, then deintegrate until zero-cross comparator fires.
// - The counter runs only during deintegration; its final count is the result.
// - Overrange during sampling starts deintegration at once, overlapping integration.
// - Each conversion waits for the sync tick: per period or per 1/32 period.
// - Fast rate integrates whole periods nearest 4 ms times the factor.
// - Medium rate integrates most whole periods not above 16.7 ms times factor.
// - Slow rate integrates most whole periods not above 100 ms.
// - Integration factor defaults to one, programmable from a quarter to six.
// - Fast and medium acquisitions run six conversions at 0, 90, 180 degrees.
// - Quick acquisition at fast or medium runs five conversions.
// - Slow acquisitions run eight conversions at 0, 90, 180, 270 degrees.
`timescale 1ns/1ns
`include "sine_ref_defines.svh"
module sine_ref_dual_slope_sequencer #(
  parameter int FAST_CYCLES = `FAST_TIME_US * `CLK_MHZ,
  parameter int MED_CYCLES = `MED_TIME_US * `CLK_MHZ,
  parameter int SLOW_CYCLES = `SLOW_TIME_US * `CLK_MHZ
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  // Converter comparators
  input wire logic zero_cross_compare_n,
  input wire logic integrator_overrange_n,
  // Generator and detector controls
  output logic [7:0] test_dac,
  output logic [7:0] ref_dac,
  output logic [1:0] filter_sel,
  output logic sync_count_clock,
  output logic integrate,
  output logic deintegrate
);

  // Offset-binary sine, quarter table mirrored over the period
  function automatic logic [7:0] sine_word(input logic [5:0] a);
    logic [4:0] q;
    logic [6:0] m;
    q = a[4] ? (5'h10 - {1'b0, a[3:0]}) : {1'b0, a[3:0]};
    unique case (q)
      5'h00: m = 7'h00;
      5'h01: m = 7'h0C;
      5'h02: m = 7'h19;
      5'h03: m = 7'h25;
      5'h04: m = 7'h31;
      5'h05: m = 7'h3C;
      5'h06: m = 7'h47;
      5'h07: m = 7'h51;
      5'h08: m = 7'h5A;
      5'h09: m = 7'h62;
      5'h0A: m = 7'h6A;
      5'h0B: m = 7'h70;
      5'h0C: m = 7'h75;
      5'h0D: m = 7'h7A;
      5'h0E: m = 7'h7D;
      5'h0F: m = 7'h7E;
      default: m = 7'h7F;
    endcase
    return a[5] ? (8'h80 - {1'b0, m}) : (8'h80 + {1'b0, m});
  endfunction

  // Quadrant shift done by adding the phase to the f and 2f bits, with a carry from 2f into f
  function automatic logic [5:0] shift_addr(input logic [5:0] a, input logic [1:0] ph);
    logic b4;
    logic b5;
    b4 = a[4] ^ ph[0];
    b5 = a[5] ^ ph[1] ^ (ph[0] & a[4]);
    return {b5, b4, a[3:0]};
  endfunction

  sine_ref_pkg::ctrl_type ctrl_ff;
  sine_ref_pkg::state_type state_ff;
  sine_ref_pkg::state_type nxt_state;
  logic [15:0] divide_ff;
  logic [4:0] factor_ff;
  logic [15:0] div_cnt_ff;
  logic [5:0] addr_ff;
  logic [7:0] test_dac_ff;
  logic [7:0] ref_dac_ff;
  logic [1:0] filter_sel_ff;
  logic sync_ff;
  logic integrate_ff;
  logic nxt_integrate;
  logic deintegrate_ff;
  logic nxt_deintegrate;
  logic [2:0] conv_idx_ff;
  logic [2:0] nxt_conv_idx;
  logic [5:0] per_cnt_ff;
  logic [31:0] elapsed_ff;
  logic [31:0] nxt_elapsed;
  logic [23:0] meas_cnt_ff;
  logic [23:0] nxt_meas_cnt;
  logic ready_ff;
  logic nxt_ready;
  logic done_ff;
  logic nxt_done;
  logic [31:0] rdata_ff;

  // Bus decode
  wire wr_ctrl = wr_stb && (addr == `REG_CTRL);
  wire wr_divide = wr_stb && (addr == `REG_DIVIDE);
  wire wr_factor = wr_stb && (addr == `REG_FACTOR);
  wire rd_result = rd_stb && (addr == `REG_RESULT);
  wire start_req = wr_ctrl && wdata[`CTRL_START_BIT];
  wire [4:0] factor_in = wdata[4:0];
  wire [4:0] factor_clamped = (factor_in < `FACTOR_MIN) ? `FACTOR_MIN :
                              (factor_in > `FACTOR_MAX) ? `FACTOR_MAX : factor_in;

  // Timebase: one 64f tick every divide+1 clocks
  wire tick64 = (div_cnt_ff == divide_ff);
  wire low_freq = (divide_ff >= `LOW_FREQ_DIV);
  // Long periods sync on every other step so the pause stays short
  wire sync_pulse = tick64 && (low_freq ? addr_ff[0] : (addr_ff == 6'h3F));
  wire [1:0] cur_phase = conv_idx_ff[2:1];
  wire [5:0] ref_addr = shift_addr(addr_ff, cur_phase);
  wire [1:0] nxt_filter = (divide_ff < `FILT_DIV_1) ? 2'h0 :
                          (divide_ff < `FILT_DIV_2) ? 2'h1 :
                          (divide_ff < `FILT_DIV_3) ? 2'h2 : 2'h3;

  // Conversions per acquisition
  wire is_slow = (ctrl_ff.rate == sine_ref_pkg::RATE_SLOW);
  wire [3:0] n_conv = is_slow ? `CONV_SLOW :
                      (ctrl_ff.quick ? {1'b0, `CONV_QUICK} : {1'b0, `CONV_NORMAL});
  wire last_conv = ({1'b0, conv_idx_ff} + 4'h1) == n_conv;

  // Integration window in quarter-cycle units
  wire [31:0] p_cyc = {9'h000, 17'({1'b0, divide_ff} + 17'h00001), 6'h00};
  wire [31:0] base_cyc = is_slow ? 32'(SLOW_CYCLES) :
                         ((ctrl_ff.rate == sine_ref_pkg::RATE_MEDIUM) ? 32'(MED_CYCLES) : 32'(FAST_CYCLES));
  wire [31:0] eff_factor = is_slow ? {27'h0, `FACTOR_RESET} : {27'h0, factor_ff};
  wire [31:0] target4 = base_cyc * eff_factor;
  wire [31:0] e_new = elapsed_ff + p_cyc;
  wire floor_stop = ((e_new + p_cyc) << 2) > target4;
  wire near_stop = (((e_new << 1) + p_cyc) << 2) > (target4 << 1);
  wire period_end = tick64 && (per_cnt_ff == 6'h3F);
  wire stop_integ = period_end && ((ctrl_ff.rate == sine_ref_pkg::RATE_FAST) ? near_stop : floor_stop);
  wire overrange = !integrator_overrange_n;
  wire zero_hit = !zero_cross_compare_n;

  // Register read mux
  wire [31:0] status_word = ({31'h0, state_ff != sine_ref_pkg::S_IDLE} << `STAT_BUSY_BIT) |
                            ({31'h0, ready_ff} << `STAT_READY_BIT) |
                            ({31'h0, done_ff} << `STAT_DONE_BIT) |
                            ({29'h0, conv_idx_ff} << `STAT_IDX_LSB) |
                            ({30'h0, cur_phase} << `STAT_PHASE_LSB);
  wire [31:0] ctrl_word = {29'h0, ctrl_ff.quick, ctrl_ff.rate};
  wire [31:0] read_mux = (addr == `REG_CTRL) ? ctrl_word :
                         (addr == `REG_DIVIDE) ? {16'h0000, divide_ff} :
                         (addr == `REG_FACTOR) ? {27'h0, factor_ff} :
                         (addr == `REG_STATUS) ? status_word :
                         (addr == `REG_RESULT) ? {8'h00, meas_cnt_ff} : 32'h0;

  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_integrate = integrate_ff;
    nxt_deintegrate = deintegrate_ff;
    nxt_conv_idx = conv_idx_ff;
    nxt_elapsed = elapsed_ff;
    nxt_meas_cnt = meas_cnt_ff;
    // Result read clears ready, but a finishing conversion wins
    nxt_ready = ready_ff && !rd_result;
    nxt_done = done_ff;
    unique case (state_ff)
      sine_ref_pkg::S_IDLE: begin
        if (start_req) begin
          nxt_state = sine_ref_pkg::S_SYNC;
          nxt_conv_idx = 3'h0;
          nxt_done = 1'b0;
        end
      end
      sine_ref_pkg::S_SYNC: begin
        if (sync_pulse) begin
          nxt_state = sine_ref_pkg::S_INTEG;
          nxt_integrate = 1'b1;
          nxt_elapsed = 32'h0;
          nxt_ready = 1'b0;
        end
      end
      sine_ref_pkg::S_INTEG: begin
        if (period_end) begin
          nxt_elapsed = e_new;
        end
        if (deintegrate_ff) begin
          nxt_meas_cnt = meas_cnt_ff + 24'h000001;
        end else if (overrange || stop_integ) begin
          nxt_deintegrate = 1'b1;
          nxt_meas_cnt = 24'h000000;
        end
        if (stop_integ) begin
          nxt_integrate = 1'b0;
          nxt_state = sine_ref_pkg::S_DEINT;
        end
      end
      sine_ref_pkg::S_DEINT: begin
        if (zero_hit) begin
          nxt_deintegrate = 1'b0;
          nxt_ready = 1'b1;
          if (last_conv) begin
            nxt_state = sine_ref_pkg::S_IDLE;
            nxt_done = 1'b1;
          end else begin
            nxt_state = sine_ref_pkg::S_SYNC;
            nxt_conv_idx = conv_idx_ff + 3'h1;
          end
        end else begin
          nxt_meas_cnt = meas_cnt_ff + 24'h000001;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff <= '{quick: 1'b0, rate: sine_ref_pkg::RATE_SLOW};
      divide_ff <= `DIVIDE_RESET;
      factor_ff <= `FACTOR_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff.rate <= (wdata[1:0] == 2'h3) ? sine_ref_pkg::RATE_SLOW : sine_ref_pkg::rate_type'(wdata[1:0]);
        ctrl_ff.quick <= wdata[`CTRL_QUICK_BIT];
      end
      if (wr_divide) begin
        divide_ff <= wdata[15:0];
      end
      if (wr_factor) begin
        factor_ff <= factor_clamped;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt_ff <= 16'h0000;
      addr_ff <= 6'h00;
      per_cnt_ff <= 6'h00;
    end else begin
      div_cnt_ff <= tick64 ? 16'h0000 : div_cnt_ff + 16'h0001;
      if (tick64) begin
        addr_ff <= addr_ff + 6'h01;
      end
      if (state_ff != sine_ref_pkg::S_INTEG) begin
        per_cnt_ff <= 6'h00;
      end else if (tick64) begin
        per_cnt_ff <= per_cnt_ff + 6'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      test_dac_ff <= 8'h80;
      ref_dac_ff <= 8'h80;
      filter_sel_ff <= 2'h0;
      sync_ff <= 1'b0;
    end else begin
      test_dac_ff <= sine_word(addr_ff);
      ref_dac_ff <= sine_word(ref_addr);
      filter_sel_ff <= nxt_filter;
      sync_ff <= sync_pulse;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= sine_ref_pkg::S_IDLE;
      integrate_ff <= 1'b0;
      deintegrate_ff <= 1'b0;
      conv_idx_ff <= 3'h0;
      elapsed_ff <= 32'h0;
      meas_cnt_ff <= 24'h000000;
      ready_ff <= 1'b0;
      done_ff <= 1'b0;
      rdata_ff <= 32'h0;
    end else begin
      state_ff <= nxt_state;
      integrate_ff <= nxt_integrate;
      deintegrate_ff <= nxt_deintegrate;
      conv_idx_ff <= nxt_conv_idx;
      elapsed_ff <= nxt_elapsed;
      meas_cnt_ff <= nxt_meas_cnt;
      ready_ff <= nxt_ready;
      done_ff <= nxt_done;
      rdata_ff <= rd_stb ? read_mux : 32'h0;
    end
  end

  assign rdata = rdata_ff;
  assign test_dac = test_dac_ff;
  assign ref_dac = ref_dac_ff;
  assign filter_sel = filter_sel_ff;
  assign sync_count_clock = sync_ff;
  assign integrate = integrate_ff;
  assign deintegrate = deintegrate_ff;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  chk_addr_step: assert property (tick64 |=> addr_ff == $past(addr_ff) + 6'h01)
    else $error("divider chain did not advance on tick");
  chk_test_table: assert property (##1 test_dac_ff == sine_word($past(addr_ff)))
    else $error("test word does not match sine table");
  chk_ref_quadrant: assert property (##1 ref_dac_ff == sine_word($past(addr_ff) + {$past(cur_phase), 4'h0}))
    else $error("reference word not shifted by phase");
  chk_zero_ends_deint: assert property (state_ff == sine_ref_pkg::S_DEINT && zero_hit |=> !deintegrate_ff)
    else $error("deintegration kept running after zero cross");
  chk_count_gated: assert property (deintegrate_ff && $past(deintegrate_ff) |-> meas_cnt_ff == $past(meas_cnt_ff) + 24'h000001)
    else $error("counter not counting during deintegration");
  chk_count_holds: assert property (!deintegrate_ff ##1 !deintegrate_ff |-> $stable(meas_cnt_ff))
    else $error("counter moved outside deintegration");
  chk_overrange_overlap: assert property (state_ff == sine_ref_pkg::S_INTEG && overrange |=> deintegrate_ff)
    else $error("overrange did not start deintegration");
  chk_integ_floor: assert property ($fell(integrate_ff) && ctrl_ff.rate != sine_ref_pkg::RATE_FAST
    |-> (elapsed_ff << 2) <= target4 && elapsed_ff != 32'h0)
    else $error("integration exceeded the allowed window");
  chk_acq_length: assert property ($rose(done_ff) |-> {1'b0, conv_idx_ff} + 4'h1 == n_conv)
    else $error("wrong number of conversions in acquisition");
  chk_sync_start: assert property ($rose(integrate_ff) |-> $past(sync_pulse))
    else $error("integration started off the sync tick");

  cov_overlap: cover property (integrate_ff && deintegrate_ff);
  cov_quick_done: cover property ($rose(done_ff) && ctrl_ff.quick && !is_slow);
  cov_slow_done: cover property ($rose(done_ff) && is_slow);

endmodule

// File: verification/integrator_model.sv
`timescale 1ns/1ns
module integrator_model (
  // Clock
  input wire logic clk,
  // Sequencer controls
  input wire logic integrate,
  input wire logic deintegrate,
  // Scenario knobs
  input wire logic [15:0] deint_len,
  input wire logic [15:0] ovr_at,
  // Comparators
  output logic zero_cross_compare_n,
  output logic integrator_overrange_n
);
  logic [15:0] icnt_ff;
  logic [15:0] dcnt_ff;
  always @(posedge clk) begin
    icnt_ff <= integrate ? icnt_ff + 16'h0001 : 16'h0000;
    dcnt_ff <= deintegrate ? dcnt_ff + 16'h0001 : 16'h0000;
  end
  // Sits low when idle, so a sequencer that listens outside a conversion is caught
  assign zero_cross_compare_n = !((deintegrate && dcnt_ff >= deint_len) || !(integrate || deintegrate));
  assign integrator_overrange_n = !(integrate && ovr_at != 16'h0000 && icnt_ff >= ovr_at);
endmodule

// File: verification/test_sine_ref_dual_slope_sequencer.sv
`timescale 1ns/1ns
`include "sine_ref_defines.svh"
module test_sine_ref_dual_slope_sequencer;
  localparam int FB = 400;
  localparam int MB = 1000;
  localparam int SB = 3000;
  localparam int P = 256;
  logic clk, reset_n, wr_stb, rd_stb;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [7:0] test_dac, ref_dac;
  logic [1:0] filter_sel;
  logic sync_count_clock, integrate, deintegrate, zero_cross_compare_n, integrator_overrange_n;
  logic [15:0] dlen, ovr_at;
  logic [7:0] tbl [64];
  logic [7:0] qt [17] = '{8'h00, 8'h0C, 8'h19, 8'h25, 8'h31, 8'h3C, 8'h47, 8'h51, 8'h5A,
    8'h62, 8'h6A, 8'h70, 8'h75, 8'h7A, 8'h7D, 8'h7E, 8'h7F};
  logic [31:0] fw [3] = '{32'h0, 32'h1F, 32'h6};
  logic [31:0] fe [3] = '{32'h1, 32'h18, 32'h6};
  logic [15:0] fd [3] = '{16'h0010, 16'h0100, 16'h0300};
  int fails, compares, nconv, exp_i, last_d, ic, dc, gap;
  logic pi, pd;

  sine_ref_dual_slope_sequencer #(.FAST_CYCLES(FB), .MED_CYCLES(MB), .SLOW_CYCLES(SB)) dut_u (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .zero_cross_compare_n(zero_cross_compare_n),
    .integrator_overrange_n(integrator_overrange_n), .test_dac(test_dac), .ref_dac(ref_dac),
    .filter_sel(filter_sel), .sync_count_clock(sync_count_clock), .integrate(integrate),
    .deintegrate(deintegrate));

  integrator_model far_u (
    .clk(clk), .integrate(integrate), .deintegrate(deintegrate), .deint_len(dlen), .ovr_at(ovr_at),
    .zero_cross_compare_n(zero_cross_compare_n), .integrator_overrange_n(integrator_overrange_n));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task end_sim();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task hang();
    chk(32'h0, 32'h1);
    end_sim();
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask

  // Whole periods of integration the rate rules call for
  function automatic int kexp(input int r, input int f);
    int b;
    int k;
    b = r == 0 ? FB : (r == 1 ? MB : SB);
    if (r > 1) f = 4;
    k = 1;
    while (r == 0 ? (2 * k + 1) * P * 2 <= b * f : (k + 1) * P * 4 <= b * f) k++;
    return k * P;
  endfunction

  // Some table address gives this test word and, p quarters on, this reference word
  function automatic logic pm(input logic [7:0] t, input logic [7:0] r, input int p);
    for (int a = 0; a < 64; a++) if (tbl[a] === t && tbl[(a + 16 * p) % 64] === r) return 1'b1;
    return 1'b0;
  endfunction

  always @(posedge clk) begin
    if (integrate && !pi) begin
      chk(sync_count_clock, 1);
      chk(pm(test_dac, ref_dac, nconv / 2), 1);
      if (nconv > 0) chk(gap <= P + 3, 1);
      nconv++;
    end
    if (!integrate && pi) chk(ic, exp_i);
    if (deintegrate && !pd && integrate) chk(ic, ovr_at + 1);
    if (!deintegrate && pd) begin
      chk(dc, ovr_at != 0 ? exp_i - ovr_at : dlen + 1);
      // Counter is cleared on the rising edge and frozen on the zero-cross edge
      last_d = dc - 1;
    end
    ic = integrate ? ic + 1 : 0;
    dc = deintegrate ? dc + 1 : 0;
    gap = (integrate || deintegrate) ? 0 : gap + 1;
    pi = integrate;
    pd = deintegrate;
  end

  task acq(input logic [1:0] r, input logic q, input logic [15:0] a);
    logic [31:0] s;
    logic [31:0] v;
    int n;
    int f;
    f = 1 + $urandom % 8;
    ovr_at = a;
    dlen = a != 0 ? 16'h0001 : 16'(1 + $urandom % 200);
    exp_i = kexp(r == 2'h3 ? 2 : r, f);
    wr(`REG_FACTOR, f);
    nconv = 0;
    wr(`REG_CTRL, {23'h0, 1'b1, 5'h0, q, r});
    // Second start lands while busy and must not restart the sequence
    wr(`REG_CTRL, {23'h0, 1'b1, 5'h0, q, r});
    for (n = 0; n < 30000; n++) begin
      rd(`REG_STATUS, s);
      if (s[`STAT_READY_BIT]) begin
        rd(`REG_RESULT, v);
        chk(v, last_d);
      end
      if (s[`STAT_DONE_BIT] && !s[`STAT_BUSY_BIT]) break;
    end
    if (n == 30000) hang();
    chk(nconv, r[1] ? 8 : (q ? 5 : 6));
    $display("acq rate=%0d quick=%0d done", r, q);
  endtask

  initial begin
    int n;
    logic [31:0] v;
    reset_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    dlen = 16'h0001;
    ovr_at = 16'h0000;
    {fails, compares, nconv, exp_i, last_d, ic, dc, gap} = '0;
    pi = 1'b0;
    pd = 1'b0;
    for (int a = 0; a < 64; a++)
      tbl[a] = a < 32 ? 8'h80 + qt[a < 16 ? a : 32 - a] : 8'h80 - qt[a < 48 ? a - 32 : 64 - a];
    void'($urandom(80922));
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    // Shrink the divider at once, before its count can pass the new limit
    wr(`REG_DIVIDE, 32'h3);
    for (n = 0; n < 300 && test_dac !== 8'h8C; n++) begin
      @(posedge clk);
      #1;
    end
    if (n == 300) hang();
    for (n = 0; n < 128; n++) begin
      chk(test_dac, tbl[(n + 1) % 64]);
      chk(ref_dac, tbl[(n + 1) % 64]);
      repeat (4) @(posedge clk);
      #1;
    end
    chk(filter_sel, 0);
    $display("generator done");
    acq(2'h0, 1'b0, 16'h0000);
    acq(2'h1, 1'b0, 16'h0000);
    acq(2'h3, 1'b0, 16'h0A8C);
    acq(2'h0, 1'b1, 16'h0000);
    acq(2'h1, 1'b1, 16'h0000);
    for (n = 0; n < 3; n++) begin
      wr(`REG_DIVIDE, {16'h0, fd[n]});
      repeat (2) @(posedge clk);
      #1;
      chk(filter_sel, n + 1);
    end
    $display("filter done");
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd(`REG_FACTOR, v);
    chk(v, 32'h4);
    chk(filter_sel, 2);
    for (n = 0; n < 3; n++) begin
      wr(`REG_FACTOR, fw[n]);
      rd(`REG_FACTOR, v);
      chk(v, fe[n]);
    end
    wr(8'h14, 32'h5);
    wr(`REG_STATUS, 32'hFFFFFFFF);
    rd(`REG_FACTOR, v);
    chk(v, 32'h6);
    rd(8'h14, v);
    chk(v, 32'h0);
    rd(`REG_STATUS, v);
    chk(v, 32'h0);
    $display("registers done");
    end_sim();
  end
endmodule
